// ---- verilog/synth_ctl_regs.svh ----
// Register offsets, field positions, reset values and counts for the
// divider-word control block. Definitions only; included by bare name.
//
// Function
// - Three separate synthesizers: receive LO, transmit LO, ADC sampling clock.
// - Every fractional word is 20 bits; one step is reference over 2^20.
// - Receive LO uses 8-bit integer plus fraction; K halves for the low monitor input.
// - Transmit LO uses 8-bit integer plus fraction; K halves for the low-band output.
// - ADC clock has its own integer and fractional words, apart from the LOs.
// - ADC clock words hold their value with no periodic reprogramming.
// - With correction on, fraction gains up/(up+down); K is 8 or 48.
// - One bit, bit 22 of register 15, turns dither correction on or off.
// - Three general outputs; the third can show receive, transmit or both lock.
// - Transmit data is a 1-bit stream; output level follows its ones-density.
// - Manual carrier and sideband calibration can override the factory values.
// - Power-down modes chosen by a hardware pin or by software settings.
// - Fields live in 32 registers of 26 bits, loaded over the 4-wire port.
`ifndef SYNTH_CTL_REGS_SVH
`define SYNTH_CTL_REGS_SVH

`define NUM_REGS        32
`define REG_W           26
`define ADDR_W          5
`define FRAME_BITS      6'h20
`define HDR_BITS        6'h06
`define REG_RESET       26'h0000000

`define REG_RX_LO_INT   5'h02
`define REG_RX_LO_FRAC  5'h03
`define REG_TX_LO_INT   5'h04
`define REG_TX_LO_FRAC  5'h05
`define REG_GPO_CFG     5'h06
`define REG_CAL         5'h07
`define REG_PWR         5'h08
`define REG_ADC_FRAC    5'h0E
`define REG_ADC_INT     5'h0F
`define REG_DITHER      5'h10
`define REG_STATUS      5'h1F

`define INT_MSB         7
`define FRAC_MSB        19
`define HALF_K_BIT      8
`define DITHER_EN_BIT   22
`define GSM_MODE_BIT    23
`define UP_MSB          7
`define DN_LSB          8
`define DN_MSB          15
`define LOCK_SEL_MSB    1
`define GPO1_BIT        2
`define GPO2_BIT        3
`define GP_OUT_LOCK_DETECT_BIT        4
`define CAL_MSB         23
`define CAL_OVR_BIT     25
`define PWR_MODE_MSB    2
`define PWR_HW_BIT      3

`define ADC_K_WCDMA     6'h08
`define ADC_K_GSM       6'h30
`define TICK_DIV        8

`endif

// ---- verilog/synth_ctl_pkg.sv ----
// Types shared by the divider-word control block, its baseband model and its bench.
// Assumes the constants header is compiled alongside.
package synth_ctl_pkg;

    typedef struct packed
    {
        logic [7:0]  int_word;
        logic [19:0] frac_word;
    } synth_word_t;

    typedef enum logic [1:0]
    {
        LOCK_STATIC = 2'h0,
        LOCK_RX     = 2'h1,
        LOCK_TX     = 2'h2,
        LOCK_BOTH   = 2'h3
    } lock_sel_t;

    typedef enum logic [1:0]
    {
        SER_IDLE  = 2'h0,
        SER_SHIFT = 2'h1,
        SER_DONE  = 2'h2
    } ser_state_t;

    typedef struct packed
    {
        logic i_bit;
        logic q_bit;
    } dac_bits_t;

endpackage

// ---- verilog/cfg_reg_mem.sv ----
// Configuration register memory: one write port, two registered read ports.
// Assumes one clock and a synchronous active-low reset clearing all words.
`timescale 1ns/100ps
`include "synth_ctl_regs.svh"
module cfg_reg_mem
#(
    parameter int DEPTH = `NUM_REGS,
    parameter int WIDTH = `REG_W,
    parameter int AW    = `ADDR_W
)
(
    input  wire logic             clk_in,
    input  wire logic             resetn_in,
    input  wire logic             wr_en_in,
    input  wire logic [AW-1:0]    wr_addr_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic [AW-1:0]    rd_a_addr_in,
    output logic      [WIDTH-1:0] rd_a_data_out,
    input  wire logic [AW-1:0]    rd_b_addr_in,
    output logic      [WIDTH-1:0] rd_b_data_out
);
    typedef struct packed
    {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0]            rd_a;
        logic [WIDTH-1:0]            rd_b;
    } mem_state_t;

    mem_state_t r;
    mem_state_t n;

    always_comb
    begin
        n = r;
        // Reads see the old word on a same-cycle write
        n.rd_a = r.mem[rd_a_addr_in];
        n.rd_b = r.mem[rd_b_addr_in];
        if (wr_en_in)
        begin
            n.mem[wr_addr_in] = wr_data_in;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            r <= '0;
        end
        else
        begin
            r <= n;
        end
    end

    assign rd_a_data_out = r.rd_a;
    assign rd_b_data_out = r.rd_b;
endmodule

// ---- verilog/frac_n_synth_divider_control.sv ----
// Divider-word control for the receive LO, transmit LO and ADC clock
// synthesizers, with serial and parallel register access, lock report,
// calibration override, power-down select and transmit bit path.
// Assumes serial pins, lock flags and transmit bits are asynchronous.
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/100ps
`include "synth_ctl_regs.svh"
module frac_n_synth_divider_control
#(
    parameter int TICK_DIV = `TICK_DIV
)
(
    input  wire logic                      clk_in,
    input  wire logic                      resetn_in,
    input  wire logic [`ADDR_W-1:0]        reg_addr_in,
    input  wire logic [`REG_W-1:0]         reg_wdata_in,
    input  wire logic                      reg_wr_in,
    input  wire logic                      reg_rd_in,
    output logic      [`REG_W-1:0]         reg_rdata_out,
    input  wire logic                      spi_sclk_in,
    input  wire logic                      spi_cs_n_in,
    input  wire logic                      spi_din_in,
    output logic                           spi_dout_out,
    output logic                           spi_dout_oe_out,
    input  wire logic                      rx_lock_in,
    input  wire logic                      tx_lock_in,
    input  wire logic                      pd_pin_in,
    input  wire synth_ctl_pkg::dac_bits_t  tx_bits_in,
    input  wire logic [`CAL_MSB:0]         factory_cal_in,
    output synth_ctl_pkg::synth_word_t     rx_lo_word_out,
    output logic                           rx_lo_half_k_out,
    output synth_ctl_pkg::synth_word_t     tx_lo_word_out,
    output logic                           tx_lo_half_k_out,
    output synth_ctl_pkg::synth_word_t     adc_clk_word_out,
    output logic                           adc_carry_out,
    output logic      [5:0]                adc_scale_out,
    output logic      [2:0]                gp_out_out,
    output synth_ctl_pkg::dac_bits_t       tx_dac_bits_out,
    output logic      [`CAL_MSB:0]         cal_value_out,
    output logic      [`PWR_MODE_MSB:0]    pwr_mode_out
);
    localparam int TW = $clog2(TICK_DIV + 1);

    typedef struct packed
    {
        logic sclk_s1, sclk_s2, sclk_s3;
        logic cs_s1, cs_s2, cs_s3;
        logic din_s1, din_s2;
        logic rxl_s1, rxl_s2;
        logic txl_s1, txl_s2;
        logic pd_s1, pd_s2;
        synth_ctl_pkg::dac_bits_t tx_s1, tx_s2;
        synth_ctl_pkg::ser_state_t ser;
        logic [31:0]        sh;
        logic [5:0]         cnt;
        logic               rd_issued;
        logic               rd_load;
        logic               rd_active;
        logic [`REG_W-1:0]  dout_sh;
        logic               pend;
        logic [`ADDR_W-1:0] pend_addr;
        logic [`REG_W-1:0]  pend_data;
        logic               rd_status;
        logic [`REG_W-1:0]  rx_int, rx_frac, tx_int, tx_frac;
        logic [`REG_W-1:0]  gpo, cal, pwr, adc_frac, adc_int, dither;
        logic [TW-1:0]      tick_cnt;
        logic [8:0]         acc;
        synth_ctl_pkg::synth_word_t adc_word;
        logic               adc_carry;
        logic [2:0]         gp;
        synth_ctl_pkg::dac_bits_t dac;
        logic [`CAL_MSB:0]  cal_val;
        logic [`PWR_MODE_MSB:0] pmode;
    } state_t;

    state_t r;
    state_t n;

    logic               mem_we;
    logic [`ADDR_W-1:0] mem_waddr;
    logic [`REG_W-1:0]  mem_wdata;
    logic [`ADDR_W-1:0] rd_b_addr;
    logic [`REG_W-1:0]  rd_a_data;
    logic [`REG_W-1:0]  rd_b_data;

    cfg_reg_mem u_mem
    (
        .clk_in        (clk_in),
        .resetn_in     (resetn_in),
        .wr_en_in      (mem_we),
        .wr_addr_in    (mem_waddr),
        .wr_data_in    (mem_wdata),
        .rd_a_addr_in  (reg_addr_in),
        .rd_a_data_out (rd_a_data),
        .rd_b_addr_in  (rd_b_addr),
        .rd_b_data_out (rd_b_data)
    );

    function automatic logic [8:0] modulus(input logic [`REG_W-1:0] d);
        modulus = {1'b0, d[`UP_MSB:0]} + {1'b0, d[`DN_MSB:`DN_LSB]};
    endfunction

    logic                  sclk_rise;
    logic                  sclk_fall;
    logic                  cs_rise;
    logic                  cs_low;
    logic [9:0]            acc_sum;
    logic [27:0]           adc_cat;
    logic [28:0]           adc_sum;
    logic                  bump;

    always_comb
    begin
        sclk_rise = r.sclk_s2 && !r.sclk_s3;
        sclk_fall = !r.sclk_s2 && r.sclk_s3;
        cs_rise   = r.cs_s2 && !r.cs_s3;
        cs_low    = !r.cs_s2;
        rd_b_addr = r.sh[4:0];
        // Plain writes win the port; a latched serial frame waits for a cycle with no plain write
        mem_we    = reg_wr_in || r.pend;
        mem_waddr = reg_wr_in ? reg_addr_in : r.pend_addr;
        mem_wdata = reg_wr_in ? reg_wdata_in : r.pend_data;
        // Ten bits: accumulator plus up count can pass 511
        acc_sum   = {1'b0, r.acc} + {2'b00, r.dither[`UP_MSB:0]};
        bump      = 1'b0;
        adc_cat   = {r.adc_int[`INT_MSB:0], r.adc_frac[`FRAC_MSB:0]};
        n = r;
        n.sclk_s1 = spi_sclk_in;
        n.sclk_s2 = r.sclk_s1;
        n.sclk_s3 = r.sclk_s2;
        n.cs_s1   = spi_cs_n_in;
        n.cs_s2   = r.cs_s1;
        n.cs_s3   = r.cs_s2;
        n.din_s1  = spi_din_in;
        n.din_s2  = r.din_s1;
        n.rxl_s1  = rx_lock_in;
        n.rxl_s2  = r.rxl_s1;
        n.txl_s1  = tx_lock_in;
        n.txl_s2  = r.txl_s1;
        n.pd_s1   = pd_pin_in;
        n.pd_s2   = r.pd_s1;
        n.tx_s1   = tx_bits_in;
        n.tx_s2   = r.tx_s1;

        // Retire a taken frame first so a new one in the same cycle wins
        if (r.pend && !reg_wr_in)
        begin
            n.pend = 1'b0;
        end

        // Serial frame: R/W, 5 address bits, 26 data bits, MSB first
        n.rd_load = 1'b0;
        unique case (r.ser)
            synth_ctl_pkg::SER_IDLE:
            begin
                n.cnt       = 6'h00;
                n.rd_issued = 1'b0;
                n.rd_active = 1'b0;
                if (cs_low)
                begin
                    n.ser = synth_ctl_pkg::SER_SHIFT;
                end
            end
            synth_ctl_pkg::SER_SHIFT:
            begin
                if (sclk_rise && r.cnt != `FRAME_BITS)
                begin
                    n.sh  = {r.sh[30:0], r.din_s2};
                    n.cnt = r.cnt + 6'h01;
                end
                if (r.cnt == `HDR_BITS && r.sh[5] && !r.rd_issued)
                begin
                    n.rd_issued = 1'b1;
                    n.rd_load   = 1'b1;
                end
                if (r.rd_load)
                begin
                    n.dout_sh   = rd_b_data;
                    n.rd_active = 1'b1;
                end
                else if (sclk_fall && r.rd_active && r.cnt > `HDR_BITS)
                begin
                    n.dout_sh = {r.dout_sh[`REG_W-2:0], 1'b0};
                end
                if (cs_rise)
                begin
                    n.ser = synth_ctl_pkg::SER_DONE;
                end
            end
            synth_ctl_pkg::SER_DONE:
            begin
                // Latch only a whole write frame, never a partial one
                if (r.cnt == `FRAME_BITS && !r.sh[31])
                begin
                    n.pend      = 1'b1;
                    n.pend_addr = r.sh[30:26];
                    n.pend_data = r.sh[25:0];
                end
                n.ser = synth_ctl_pkg::SER_IDLE;
            end
            default:
            begin
                n.ser = synth_ctl_pkg::SER_IDLE;
            end
        endcase

        // Live copies of the fields that steer the synthesizers, outputs, calibration and power
        if (mem_we)
        begin
            unique case (mem_waddr)
                `REG_RX_LO_INT:  n.rx_int   = mem_wdata;
                `REG_RX_LO_FRAC: n.rx_frac  = mem_wdata;
                `REG_TX_LO_INT:  n.tx_int   = mem_wdata;
                `REG_TX_LO_FRAC: n.tx_frac  = mem_wdata;
                `REG_GPO_CFG:    n.gpo      = mem_wdata;
                `REG_CAL:        n.cal      = mem_wdata;
                `REG_PWR:        n.pwr      = mem_wdata;
                `REG_ADC_FRAC:   n.adc_frac = mem_wdata;
                `REG_ADC_INT:    n.adc_int  = mem_wdata;
                `REG_DITHER:     n.dither   = mem_wdata;
                default:         n.rd_status = r.rd_status;
            endcase
        end
        n.rd_status = reg_rd_in && (reg_addr_in == `REG_STATUS);

        // Dither: first-order accumulator, modulus up+down, one step per tick
        if (r.tick_cnt == TW'(TICK_DIV - 1))
        begin
            n.tick_cnt = '0;
            if (r.adc_int[`DITHER_EN_BIT] && modulus(r.dither) != 9'h000)
            begin
                if (acc_sum >= {1'b0, modulus(r.dither)})
                begin
                    n.acc = 9'(acc_sum - {1'b0, modulus(r.dither)});
                    bump  = 1'b1;
                end
                else
                begin
                    n.acc = acc_sum[8:0];
                end
            end
        end
        else
        begin
            n.tick_cnt = r.tick_cnt + TW'(1);
        end
        if (!r.adc_int[`DITHER_EN_BIT])
        begin
            n.acc = 9'h000;
        end
        // Fresh counts restart the phase so the accumulator stays below the modulus
        if (mem_we && mem_waddr == `REG_DITHER)
        begin
            n.acc = 9'h000;
        end
        adc_sum     = {1'b0, adc_cat} + {28'h0000000, bump};
        n.adc_word  = adc_sum[27:0];
        n.adc_carry = adc_sum[28];

        // General outputs; the third may report lock
        n.gp[0] = r.gpo[`GPO1_BIT];
        n.gp[1] = r.gpo[`GPO2_BIT];
        unique case (synth_ctl_pkg::lock_sel_t'(r.gpo[`LOCK_SEL_MSB:0]))
            synth_ctl_pkg::LOCK_STATIC: n.gp[2] = r.gpo[`GP_OUT_LOCK_DETECT_BIT];
            synth_ctl_pkg::LOCK_RX:     n.gp[2] = r.rxl_s2;
            synth_ctl_pkg::LOCK_TX:     n.gp[2] = r.txl_s2;
            synth_ctl_pkg::LOCK_BOTH:   n.gp[2] = r.rxl_s2 && r.txl_s2;
        endcase

        // Pin-selected mode forces sleep while the pin is low
        n.pmode = (r.pwr[`PWR_HW_BIT] && !r.pd_s2) ? 3'h0 : r.pwr[`PWR_MODE_MSB:0];
        // Bits reach the 1-bit DACs only outside sleep (mode 0); density sets the level
        n.dac     = (n.pmode != 3'h0) ? r.tx_s2 : 2'h0;
        n.cal_val = r.cal[`CAL_OVR_BIT] ? r.cal[`CAL_MSB:0] : factory_cal_in;
    end

    always_ff @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            r       <= '0;
            r.sclk_s1 <= 1'b0;
            r.cs_s1 <= 1'b1;
            r.cs_s2 <= 1'b1;
            r.cs_s3 <= 1'b1;
        end
        else
        begin
            r <= n;
        end
    end

    assign reg_rdata_out    = r.rd_status ? {21'h000000, r.pend, r.adc_carry,
                                             r.txl_s2, r.rxl_s2, r.ser != synth_ctl_pkg::SER_IDLE}
                                          : rd_a_data;
    assign spi_dout_out     = r.dout_sh[`REG_W-1];
    assign spi_dout_oe_out  = r.rd_active;
    assign rx_lo_word_out   = {r.rx_int[`INT_MSB:0], r.rx_frac[`FRAC_MSB:0]};
    assign rx_lo_half_k_out = r.rx_int[`HALF_K_BIT];
    assign tx_lo_word_out   = {r.tx_int[`INT_MSB:0], r.tx_frac[`FRAC_MSB:0]};
    assign tx_lo_half_k_out = r.tx_int[`HALF_K_BIT];
    assign adc_clk_word_out = r.adc_word;
    assign adc_carry_out    = r.adc_carry;
    assign adc_scale_out    = r.adc_int[`GSM_MODE_BIT] ? `ADC_K_GSM : `ADC_K_WCDMA;
    assign gp_out_out       = r.gp;
    assign tx_dac_bits_out  = r.dac;
    assign cal_value_out    = r.cal_val;
    assign pwr_mode_out     = r.pmode;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    AST_PLAIN_COMMIT: assert property (reg_wr_in && reg_addr_in == `REG_RX_LO_INT
        |=> rx_lo_word_out.int_word == $past(reg_wdata_in[`INT_MSB:0]))
        else $error("Receive integer word not taken from write");
    AST_NO_MIDFRAME: assert property (cs_low && !r.pend && !reg_wr_in
        |=> $stable(rx_lo_word_out) && $stable(tx_lo_word_out))
        else $error("Divider word changed during a frame");
    AST_ADC_HOLD: assert property (!mem_we [*2] |-> $stable(r.adc_int) && $stable(r.adc_frac))
        else $error("ADC words changed without a write");
    AST_NO_DITHER: assert property (!r.adc_int[`DITHER_EN_BIT]
        |=> {adc_carry_out, adc_clk_word_out} == {1'b0, $past(adc_cat)})
        else $error("Effective ADC word differs with correction off");
    AST_DITHER_RANGE: assert property (r.adc_int[`DITHER_EN_BIT]
        |=> ({adc_carry_out, adc_clk_word_out} - {1'b0, $past(adc_cat)}) <= 29'h1)
        else $error("Dither step larger than one fractional LSB");
    AST_DITHER_ZERO: assert property (r.dither[`UP_MSB:0] == 8'h00
        |=> adc_clk_word_out == $past(adc_cat))
        else $error("Dither bumped with zero up count");
    AST_LOCK_BOTH: assert property (r.gpo[1:0] == 2'h3 && !r.rxl_s2 |=> !gp_out_out[2])
        else $error("Combined lock shown without receive lock");
    AST_LOCK_RX: assert property (r.gpo[1:0] == 2'h1 |=> gp_out_out[2] == $past(r.rxl_s2))
        else $error("Receive lock not shown on third output");
    AST_TX_BITS: assert property (r.pwr[`PWR_HW_BIT] && !r.pd_s2
        |=> tx_dac_bits_out == 2'h0)
        else $error("Transmit bits pass in pin-forced sleep");
    AST_CAL: assert property (r.cal[`CAL_OVR_BIT] |=> cal_value_out == $past(r.cal[`CAL_MSB:0]))
        else $error("Manual calibration not applied");
    AST_ACC_BOUND: assert property (modulus(r.dither) != 9'h000
        |-> r.acc < modulus(r.dither))
        else $error("Dither accumulator reached its modulus");

    COV_SERIAL_WRITE: cover property (r.ser == synth_ctl_pkg::SER_DONE && r.cnt == `FRAME_BITS);
    COV_SERIAL_READ: cover property (r.rd_load);
    COV_DITHER_BUMP: cover property (r.adc_int[`DITHER_EN_BIT] && bump);
    COV_PEND_WAIT: cover property (r.pend && reg_wr_in);
endmodule

// ---- sim/bb_serial_master.sv ----
// Baseband-side model: serial configuration master and transmit bitstream source.
// Assumes the block samples these pins asynchronously on clk_in.
`timescale 1ns/100ps
module bb_serial_master
(
    input  wire logic                 clk_in,
    output logic                      sclk_out,
    output logic                      cs_n_out,
    output logic                      din_out,
    output synth_ctl_pkg::dac_bits_t  bits_out,
    input  wire logic                 dout_in,
    input  wire logic                 oe_in
);
    // Read-back bits and enable as seen at each rising serial clock
    logic [31:0]                      got;
    logic                             oe_got;
    initial
    begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        din_out  = 1'b0;
        bits_out = 2'h0;
    end

    // Five clocks per half period, above the four-clock minimum
    task automatic frame(input logic [31:0] w, input int nbits);
        @(posedge clk_in);
        cs_n_out <= 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            din_out <= w[31-i];
            repeat (5) @(posedge clk_in);
            got      = {got[30:0], dout_in};
            oe_got   = oe_in;
            sclk_out <= 1'b1;
            repeat (5) @(posedge clk_in);
            sclk_out <= 1'b0;
        end
        repeat (5) @(posedge clk_in);
        cs_n_out <= 1'b1;
        // Released line must not keep showing the last bit
        din_out  <= ~din_out;
    endtask

    task automatic drive_bits(input synth_ctl_pkg::dac_bits_t b);
        @(posedge clk_in);
        bits_out <= b;
    endtask
endmodule

// ---- sim/frac_n_synth_divider_control_tb.sv ----
// Self-checking bench for the divider-word control block.
// Assumes the baseband model drives the serial pins and transmit bits.
`timescale 1ns/100ps
`include "synth_ctl_regs.svh"
module frac_n_synth_divider_control_tb;
    logic                       clk_in = 1'b0;
    logic                       resetn_in = 1'b0;
    logic [`ADDR_W-1:0]         reg_addr_in = 5'h00;
    logic [`REG_W-1:0]          reg_wdata_in = 26'h0000000;
    logic                       reg_wr_in = 1'b0;
    logic                       reg_rd_in = 1'b0;
    logic [`REG_W-1:0]          reg_rdata_out;
    logic                       sclk, cs_n, din, dout, dout_oe;
    logic                       rx_lock_in = 1'b0;
    logic                       tx_lock_in = 1'b0;
    logic                       pd_pin_in = 1'b1;
    synth_ctl_pkg::dac_bits_t   bits, dac_bits;
    synth_ctl_pkg::synth_word_t rx_w, tx_w, adc_w;
    logic                       rx_half, tx_half, carry;
    logic [5:0]                 scale;
    logic [2:0]                 gp;
    logic [`CAL_MSB:0]          cal;
    logic [`PWR_MODE_MSB:0]     pwr;
    int                         fails = 0;
    int                         n_checks = 0;
    int                         cycles = 0;
    localparam logic [23:0]     FACTORY = 24'hA5C3E1;

    always #10 clk_in = ~clk_in;

    frac_n_synth_divider_control #(.TICK_DIV(1)) uut
    (
        .clk_in(clk_in), .resetn_in(resetn_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .spi_sclk_in(sclk), .spi_cs_n_in(cs_n), .spi_din_in(din),
        .spi_dout_out(dout), .spi_dout_oe_out(dout_oe),
        .rx_lock_in(rx_lock_in), .tx_lock_in(tx_lock_in), .pd_pin_in(pd_pin_in),
        .tx_bits_in(bits), .factory_cal_in(FACTORY),
        .rx_lo_word_out(rx_w), .rx_lo_half_k_out(rx_half),
        .tx_lo_word_out(tx_w), .tx_lo_half_k_out(tx_half),
        .adc_clk_word_out(adc_w), .adc_carry_out(carry), .adc_scale_out(scale),
        .gp_out_out(gp), .tx_dac_bits_out(dac_bits), .cal_value_out(cal),
        .pwr_mode_out(pwr)
    );

    bb_serial_master part
    (
        .clk_in(clk_in), .sclk_out(sclk), .cs_n_out(cs_n), .din_out(din), .bits_out(bits),
        .dout_in(dout), .oe_in(dout_oe)
    );

    task automatic check(input string what, input logic [27:0] seen, input logic [27:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            fails++;
            conclude();
        end
    end

    // Ends on a falling edge so outputs are sampled settled
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        @(negedge clk_in);
    endtask

    task automatic wr(input logic [4:0] a, input logic [25:0] d);
        @(posedge clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [25:0] exp);
        @(posedge clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        @(negedge clk_in);
        check("rdata", reg_rdata_out, exp);
    endtask

    task automatic t_lo();
        wr(`REG_RX_LO_INT, 26'h0000063);
        wr(`REG_RX_LO_FRAC, 26'h007AAAA);
        cyc(2);
        check("rx_word", rx_w, 28'h637AAAA);
        check("rx_half", rx_half, 0);
        wr(`REG_RX_LO_INT, 26'h0000163);
        wr(`REG_TX_LO_INT, 26'h0000163);
        wr(`REG_TX_LO_FRAC, 26'h0012345);
        cyc(2);
        check("rx_half_low", rx_half, 1);
        check("tx_word", tx_w, 28'h6312345);
        check("tx_half", tx_half, 1);
        rd(`REG_RX_LO_INT, 26'h0000163);
        wr(5'h1E, 26'h3FFFFFF);
        rd(5'h1E, 26'h3FFFFFF);
    endtask

    task automatic count_bumps(input int exp, input logic [28:0] hit);
        int bumps;
        bumps = 0;
        for (int i = 0; i < 100; i++)
        begin
            @(negedge clk_in);
            if ({carry, adc_w} === hit)
                bumps++;
        end
        check("bumps", bumps, exp);
    endtask

    task automatic t_adc();
        wr(`REG_ADC_FRAC, 26'h0000000);
        wr(`REG_ADC_INT, 26'h0000050);
        cyc(3);
        check("adc_wcdma", adc_w, 28'h5000000);
        check("scale_w", scale, `ADC_K_WCDMA);
        cyc(60);
        check("adc_hold", adc_w, 28'h5000000);
        wr(`REG_ADC_FRAC, 26'h0066666);
        wr(`REG_DITHER, 26'h0000302);
        wr(`REG_ADC_INT, 26'h0C0003E);
        cyc(4);
        check("scale_g", scale, `ADC_K_GSM);
        count_bumps(40, 29'h03E66667);
        wr(`REG_ADC_INT, 26'h080003E);
        cyc(4);
        count_bumps(0, 29'h03E66667);
        wr(`REG_ADC_FRAC, 26'h00FFFFF);
        wr(`REG_ADC_INT, 26'h04000FF);
        cyc(4);
        count_bumps(40, 29'h10000000);
        wr(`REG_ADC_INT, 26'h0000050);
        check("rx_apart", rx_w, 28'h637AAAA);
    endtask

    task automatic t_serial();
        part.frame({1'b0, 5'h04, 26'h00000A5}, 31);
        cyc(10);
        check("short_frame", tx_w.int_word, 8'h63);
        part.frame({1'b1, 5'h04, 26'h00000A5}, 32);
        cyc(10);
        check("read_frame", tx_w.int_word, 8'h63);
        check("ser_rdata", part.got[25:0], 26'h0000163);
        check("ser_oe", {part.oe_got, dout_oe}, 2'h2);
        fork
            part.frame({1'b0, 5'h04, 26'h00000A5}, 32);
            begin
                cyc(300);
                check("mid_frame", tx_w.int_word, 8'h63);
            end
        join
        cyc(10);
        check("ser_word", tx_w.int_word, 8'hA5);
    endtask

    task automatic t_gpo();
        logic exp;
        wr(`REG_GPO_CFG, 26'h000001C);
        cyc(2);
        check("gpo123", gp, 3'h7);
        for (int s = 1; s < 4; s++)
        begin
            wr(`REG_GPO_CFG, 26'(s));
            for (int k = 0; k < 4; k++)
            begin
                @(posedge clk_in);
                rx_lock_in <= k[0];
                tx_lock_in <= k[1];
                cyc(6);
                exp = (s == 1) ? k[0] : (s == 2) ? k[1] : (k[0] & k[1]);
                check("lock_gpo", gp[2], exp);
            end
        end
    endtask

    task automatic t_power();
        check("sleep_bits", dac_bits, 2'h0);
        wr(`REG_PWR, 26'h0000001);
        part.drive_bits(2'h2);
        cyc(6);
        check("pwr_mode", pwr, 3'h1);
        check("bits_i", dac_bits, 2'h2);
        part.drive_bits(2'h1);
        cyc(6);
        check("bits_q", dac_bits, 2'h1);
        wr(`REG_PWR, 26'h0000009);
        @(posedge clk_in);
        pd_pin_in <= 1'b0;
        cyc(6);
        check("pin_sleep", pwr, 3'h0);
        check("pin_bits", dac_bits, 2'h0);
        @(posedge clk_in);
        pd_pin_in <= 1'b1;
        cyc(6);
        check("pin_wake", pwr, 3'h1);
    endtask

    task automatic t_cal();
        wr(`REG_CAL, 26'h0123456);
        cyc(3);
        check("cal_factory", cal, FACTORY);
        wr(`REG_CAL, 26'h2123456);
        cyc(3);
        check("cal_manual", cal, 24'h123456);
        rd(`REG_STATUS, 26'h0000006);
    endtask

    initial
    begin
        repeat (16) @(posedge clk_in);
        resetn_in <= 1'b1;
        cyc(1);
        check("rst_rx", rx_w, 28'h0);
        check("rst_adc", adc_w, 28'h0);
        t_lo();
        t_adc();
        t_serial();
        t_gpo();
        t_power();
        t_cal();
        conclude();
    end
endmodule
